// >>> include/qdr_port_defs.svh
// Shared constants for the burst-of-four separate-I/O memory port
`ifndef QDR_PORT_DEFS_SVH
`define QDR_PORT_DEFS_SVH
`define DATA_W_NARROW 18
`define DATA_W_WIDE 36
`define ADDR_W_NARROW 20
`define ADDR_W_WIDE 19
`define LANE_W 9
`define BURST_LEN 4
`define BEATS_AFTER_FIRST 3'h3
`define BUF_DEPTH 2'h2
`endif

// >>> include/qdr_port_if.sv
// Pin-level link between the memory device and its controller
`timescale 1ns/10ps
`include "qdr_port_defs.svh"
interface qdr_port_if #(
  parameter int DATA_W = `DATA_W_NARROW,
  parameter int ADDR_W = `ADDR_W_NARROW
);
  localparam int LANES = DATA_W / `LANE_W;
  logic k_pos;
  logic write_port_select_n;
  logic read_port_select_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [LANES-1:0] byte_write_select_n;
  logic [DATA_W-1:0] q;
  logic q_oe;
  logic output_valid_flag;
  logic echo_output_strobe;
  logic echo_output_strobe_n;
  modport device (
    input k_pos, write_port_select_n, read_port_select_n, addr, d,
    input byte_write_select_n,
    output q, q_oe, output_valid_flag, echo_output_strobe,
    output echo_output_strobe_n
  );
  modport controller (
    output k_pos, write_port_select_n, read_port_select_n, addr, d,
    output byte_write_select_n,
    input q, q_oe, output_valid_flag, echo_output_strobe,
    input echo_output_strobe_n
  );
endinterface : qdr_port_if

// >>> include/qdr_port_pkg.sv
// Types shared by both ends of the memory port
package qdr_port_pkg;
  typedef logic [1:0] beat_t;
  typedef logic [2:0] left_t;
endpackage : qdr_port_pkg

// >>> logic/qdr_sram_controller.sv
// Controller end: strobe generation, command issue and read buffering
`timescale 1ns/10ps
`include "qdr_port_defs.svh"
module qdr_sram_controller
  import qdr_port_pkg::*;
#(
  parameter int DATA_W = `DATA_W_NARROW,
  parameter int ADDR_W = `ADDR_W_NARROW
) (
  input wire logic core_clk,
  input wire logic reset,
  qdr_port_if.controller port,
  input wire logic wr_req,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [`BURST_LEN*DATA_W-1:0] wr_data,
  input wire logic [`BURST_LEN*(DATA_W/`LANE_W)-1:0] wr_lane_n,
  output logic wr_ready,
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic rd_ready,
  output logic rd_valid,
  output logic [`BURST_LEN*DATA_W-1:0] rd_data,
  input wire logic rd_take
);
  localparam int LANES = DATA_W / `LANE_W;
  localparam int BW = `BURST_LEN * DATA_W;
  localparam int LW = `BURST_LEN * LANES;

  typedef struct packed {
    logic k;
    logic wps_n;
    logic rps_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d;
    logic [LANES-1:0] bws_n;
    left_t wr_left;
    logic [BW-1:0] wr_shift;
    logic [LW-1:0] lane_shift;
    logic rd_out;
    beat_t cap_beat;
    logic [BW-1:0] cap;
    logic [1:0] count;
    logic [BW-1:0] buf0;
    logic [BW-1:0] buf1;
  } state_t;

  state_t state;
  state_t next_state;
  logic issue_edge;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Issue: outputs set up for the edge on which K rises
  assign issue_edge = !state.k;
  assign rd_ready = issue_edge && !state.rd_out && state.count < `BUF_DEPTH;
  assign wr_ready = issue_edge && state.wr_left == 3'h0
                    && !(rd_req && rd_ready);
  assign push = port.output_valid_flag && state.cap_beat == 2'h3;
  assign pop = rd_take && state.count != 2'h0;

  always_comb begin
    next_state = state;
    next_state.k = !state.k;
    next_state.wps_n = 1'b1;
    next_state.rps_n = 1'b1;
    next_state.bws_n = '1;
    if (rd_req && rd_ready) begin
      next_state.rps_n = 1'b0;
      next_state.addr = rd_addr;
      next_state.rd_out = 1'b1;
    end else if (wr_req && wr_ready) begin
      next_state.wps_n = 1'b0;
      next_state.addr = wr_addr;
      next_state.d = wr_data[DATA_W-1:0];
      next_state.bws_n = wr_lane_n[LANES-1:0];
      next_state.wr_shift = wr_data >> DATA_W;
      next_state.lane_shift = wr_lane_n >> LANES;
      next_state.wr_left = `BEATS_AFTER_FIRST;
    end
    if (state.wr_left != 3'h0) begin
      // Remaining beats on successive strobe edges
      next_state.d = state.wr_shift[DATA_W-1:0];
      next_state.bws_n = state.lane_shift[LANES-1:0];
      next_state.wr_shift = state.wr_shift >> DATA_W;
      next_state.lane_shift = state.lane_shift >> LANES;
      next_state.wr_left = state.wr_left - 3'h1;
    end
    if (port.output_valid_flag) begin
      next_state.cap[state.cap_beat*DATA_W +: DATA_W] = port.q;
      next_state.cap_beat = state.cap_beat + 2'h1;
    end
    if (push) begin
      next_state.rd_out = 1'b0;
    end
    // Two-entry buffer; issue is held off so it never overflows
    if (pop) begin
      next_state.buf0 = state.buf1;
    end
    if (push) begin
      if (state.count == 2'h0 || (state.count == 2'h1 && pop)) begin
        next_state.buf0 = next_state.cap;
      end else begin
        next_state.buf1 = next_state.cap;
      end
    end
    next_state.count = state.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= '0;
      state.wps_n <= 1'b1;
      state.rps_n <= 1'b1;
      state.bws_n <= '1;
    end else begin
      state <= next_state;
    end
  end

  assign port.k_pos = state.k;
  assign port.write_port_select_n = state.wps_n;
  assign port.read_port_select_n = state.rps_n;
  assign port.addr = state.addr;
  assign port.d = state.d;
  assign port.byte_write_select_n = state.bws_n;
  assign rd_valid = state.count != 2'h0;
  assign rd_data = state.buf0;
endmodule : qdr_sram_controller

// >>> logic/qdr_sram_device.sv
// Memory device end: command capture, burst storage and read launch
`timescale 1ns/10ps
`include "qdr_port_defs.svh"
module qdr_sram_device
  import qdr_port_pkg::*;
#(
  parameter int DATA_W = `DATA_W_NARROW,
  parameter int ADDR_W = `ADDR_W_NARROW
) (
  input wire logic core_clk,
  input wire logic reset,
  qdr_port_if.device port
);
  localparam int LANES = DATA_W / `LANE_W;
  // Word address is the burst address with the beat index below it
  localparam int DEPTH = 1 << (ADDR_W + 2);

  // Burst phase of each port, one-hot
  typedef enum logic [1:0] {
    PORT_IDLE = 2'h1,
    PORT_BURST = 2'h2
  } phase_t;

  typedef struct packed {
    // Write port
    phase_t wr_phase;
    left_t wr_left;
    logic [ADDR_W-1:0] wr_addr;
    beat_t wr_beat;
    // Read port
    phase_t rd_phase;
    left_t rd_left;
    logic [ADDR_W-1:0] rd_addr;
    beat_t rd_beat;
    // Registered pins
    logic [DATA_W-1:0] q;
    logic q_oe;
    logic valid;
    logic echo;
  } state_t;

  state_t state;
  state_t next_state;
  // One array, interleaved by beat index in the low address bits
  logic [DATA_W-1:0] mem [DEPTH];

  logic wr_idle;
  logic rd_idle;
  logic wr_start;
  logic rd_start;
  logic wr_beat_en;
  logic rd_launch;
  logic wr_last;
  logic rd_last;
  logic [ADDR_W+1:0] wr_index;
  logic [ADDR_W+1:0] rd_index;

  // Datapath of one write beat
  logic [DATA_W-1:0] lane_mask;
  logic [DATA_W-1:0] merged_word;

  ////////////////////////////////////////////////////////////////////////
  // Command capture
  assign wr_idle = state.wr_phase == PORT_IDLE;
  assign rd_idle = state.rd_phase == PORT_IDLE;
  // A select that arrives while its own burst runs is dropped silently
  assign wr_start = port.k_pos && !port.write_port_select_n
                    && wr_idle;
  assign rd_start = port.k_pos && !port.read_port_select_n
                    && rd_idle;
  assign wr_beat_en = wr_start || state.wr_phase == PORT_BURST;
  assign rd_launch = rd_start || state.rd_phase == PORT_BURST;
  // The last beat frees its port for the next K edge
  assign wr_last = state.wr_left == 3'h1;
  assign rd_last = state.rd_left == 3'h1;
  // Address latched only on a select, otherwise ignored; a read and a
  // write selected on the same K edge both take the one shared address
  assign wr_index = wr_start ? {port.addr, 2'h0}
                             : {state.wr_addr, state.wr_beat};
  assign rd_index = rd_start ? {port.addr, 2'h0}
                             : {state.rd_addr, state.rd_beat};

  ////////////////////////////////////////////////////////////////////////
  // Lane-gated storage
  // A whole-word merge keeps a single writer on the array; a RAM with
  // byte enables would save the read of the old word
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign lane_mask[i*`LANE_W +: `LANE_W] =
      {`LANE_W{!port.byte_write_select_n[i]}};
  end
  assign merged_word = (mem[wr_index] & ~lane_mask)
                       | (port.d & lane_mask);

  always_ff @(posedge core_clk) begin
    if (wr_beat_en) begin
      mem[wr_index] <= merged_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst bookkeeping
  always_comb begin
    next_state = state;
    // Echo runs free, the inverse of K one cycle late, so it stays locked to it
    next_state.echo = !port.k_pos;

    // Write port: address taken once, then beats counted down
    case (state.wr_phase)
      PORT_IDLE: begin
        if (wr_start) begin
          next_state.wr_phase = PORT_BURST;
          next_state.wr_addr = port.addr;
          next_state.wr_beat = 2'h1;
          next_state.wr_left = `BEATS_AFTER_FIRST;
        end
      end
      PORT_BURST: begin
        next_state.wr_beat = state.wr_beat + 2'h1;
        next_state.wr_left = state.wr_left - 3'h1;
        if (wr_last) begin
          next_state.wr_phase = PORT_IDLE;
        end
      end
      default: begin
        // Unreachable code: fall back to idle
        next_state.wr_phase = PORT_IDLE;
        next_state.wr_left = 3'h0;
      end
    endcase

    // Read port: same count, one beat launched per strobe edge
    case (state.rd_phase)
      PORT_IDLE: begin
        if (rd_start) begin
          next_state.rd_phase = PORT_BURST;
          next_state.rd_addr = port.addr;
          next_state.rd_beat = 2'h1;
          next_state.rd_left = `BEATS_AFTER_FIRST;
        end
      end
      PORT_BURST: begin
        next_state.rd_beat = state.rd_beat + 2'h1;
        next_state.rd_left = state.rd_left - 3'h1;
        if (rd_last) begin
          next_state.rd_phase = PORT_IDLE;
        end
      end
      default: begin
        // Unreachable code: fall back to idle
        next_state.rd_phase = PORT_IDLE;
        next_state.rd_left = 3'h0;
      end
    endcase

    // Read launch: each beat leaves a flop, never the array directly
    if (rd_launch) begin
      next_state.q = mem[rd_index];
      next_state.q_oe = 1'b1;
      next_state.valid = 1'b1;
    end else begin
      // Pending burst done and port deselected: release the bus, and
      // show zeros rather than a stale beat while it floats
      next_state.q = '0;
      next_state.q_oe = 1'b0;
      next_state.valid = 1'b0;
    end
  end

  // Control state and the q flop are reset; the array keeps its contents
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= '0;
      state.wr_phase <= PORT_IDLE;
      state.rd_phase <= PORT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins
  assign port.q = state.q;
  assign port.q_oe = state.q_oe;
  assign port.output_valid_flag = state.valid;
  // Both echo outputs come from one flop so the pair cannot skew
  assign port.echo_output_strobe = state.echo;
  assign port.echo_output_strobe_n = !state.echo;
endmodule : qdr_sram_device

// >>> tb/qdr_port_assertions.sv
// Timing checks on the link between memory device and controller
`timescale 1ns/10ps
module qdr_port_assertions #(
  parameter int DATA_W = 18,
  parameter int ADDR_W = 20
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic k_pos,
  input wire logic write_port_select_n,
  input wire logic read_port_select_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] d,
  input wire logic [DATA_W/9-1:0] byte_write_select_n,
  input wire logic [DATA_W-1:0] q,
  input wire logic q_oe,
  input wire logic output_valid_flag,
  input wire logic echo_output_strobe,
  input wire logic echo_output_strobe_n
);
  logic [2:0] rd_left;
  logic rd_go;
  logic wr_go;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // A new read may be taken on the last beat of the running one
  assign rd_go = k_pos && !read_port_select_n && rd_left <= 3'h1;
  assign wr_go = k_pos && !write_port_select_n;
  always_ff @(posedge core_clk) begin
    if (reset) rd_left <= 3'h0;
    else if (rd_go) rd_left <= 3'h4;
    else if (rd_left != 3'h0) rd_left <= rd_left - 3'h1;
  end
  ////////////////////////////////////////////////////////////////////
  kpos_toggle_a: assert property (
    !$past(reset) |-> k_pos != $past(k_pos)) else $error("k_pos stuck");
  echo_follow_a: assert property (
    !$past(reset) |-> echo_output_strobe == !$past(k_pos))
    else $error("echo strobe not tracking k_pos");
  echo_pair_a: assert property (
    echo_output_strobe_n != echo_output_strobe) else $error("echo pair");
  valid_burst_a: assert property (
    output_valid_flag == (rd_left != 3'h0)) else $error("valid window");
  drive_window_a: assert property (
    q_oe == output_valid_flag) else $error("q_oe differs from valid");
  wsel_kedge_a: assert property (
    !write_port_select_n |-> k_pos) else $error("write select off K");
  rsel_kedge_a: assert property (
    !read_port_select_n |-> k_pos) else $error("read select off K");
  rd_gap_a: assert property (
    rd_go |=> read_port_select_n [*3]) else $error("read select in burst");
  wr_gap_a: assert property (
    wr_go |=> write_port_select_n [*3]) else $error("write in burst");
  ////////////////////////////////////////////////////////////////////
  cover property (rd_go);
  cover property (wr_go);
  cover property (rd_go ##[1:4] wr_go);
endmodule : qdr_port_assertions

// >>> tb/quad_rate_sram_port_interface_test.sv
// Bench joining controller and device across the pin-level link
`timescale 1ns/10ps
module quad_rate_sram_port_interface_test;
  import qdr_port_pkg::*;
  localparam int AW = 4;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic wr_req = 1'b0;
  logic rd_req = 1'b0;
  logic rd_take = 1'b0;
  logic wr_ready, rd_ready, rd_valid;
  logic [AW-1:0] wr_addr = '0;
  logic [AW-1:0] rd_addr = '0;
  logic [71:0] wr_data = '0;
  logic [71:0] rd_data;
  logic [7:0] wr_lane_n = 8'hFF;
  logic [7:0] lns [4] = '{8'hFF, 8'hAA, 8'h55, 8'hFE};
  logic [17:0] mem [64];
  logic [71:0] exp_q [$];
  int seed = 23443;
  int cycles = 0;
  int fails = 0;
  int compares = 0;
  always #5 core_clk = ~core_clk;
  qdr_port_if #(.DATA_W(18), .ADDR_W(AW)) link ();
  qdr_sram_device #(.DATA_W(18), .ADDR_W(AW)) qdr_sram_device_inst (
    .core_clk(core_clk), .reset(reset), .port(link));
  qdr_sram_controller #(.DATA_W(18), .ADDR_W(AW)) qdr_sram_controller_inst (
    .core_clk(core_clk), .reset(reset), .port(link), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_lane_n(wr_lane_n),
    .wr_ready(wr_ready), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_take(rd_take));
  qdr_port_assertions #(.DATA_W(18), .ADDR_W(AW)) qdr_port_assertions_inst (
    .core_clk(core_clk), .reset(reset), .k_pos(link.k_pos),
    .write_port_select_n(link.write_port_select_n),
    .read_port_select_n(link.read_port_select_n), .addr(link.addr),
    .d(link.d), .byte_write_select_n(link.byte_write_select_n), .q(link.q),
    .q_oe(link.q_oe), .output_valid_flag(link.output_valid_flag),
    .echo_output_strobe(link.echo_output_strobe),
    .echo_output_strobe_n(link.echo_output_strobe_n));
  ////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // Budget of 8000 cycles against a run of a few hundred, with wide margin
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [71:0] e,
    input logic [71:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [71:0] rnd();
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    return r[71:0];
  endfunction : rnd
  function automatic logic [71:0] expect_rd(input logic [AW-1:0] a);
    return {mem[{a, 2'h3}], mem[{a, 2'h2}], mem[{a, 2'h1}], mem[{a, 2'h0}]};
  endfunction : expect_rd
  task automatic wr(input logic [AW-1:0] a, input logic [71:0] dt,
    input logic [7:0] ln);
    @(negedge core_clk);
    {wr_req, wr_addr, wr_data, wr_lane_n} = {1'b1, a, dt, ln};
    while (wr_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    wr_req = 1'b0;
    // Lane i is beat i/2, half i%2; a high select leaves that half alone
    for (int i = 0; i < 8; i++) begin
      if (!ln[i]) mem[{a, i[2:1]}][i[0]*9 +: 9] = dt[i*9 +: 9];
    end
  endtask : wr
  task automatic rd(input logic [AW-1:0] a);
    @(negedge core_clk);
    {rd_req, rd_addr} = {1'b1, a};
    while (rd_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    rd_req = 1'b0;
    exp_q.push_back(expect_rd(a));
  endtask : rd
  task automatic take();
    @(negedge core_clk);
    while (rd_valid !== 1'b1) @(negedge core_clk);
    chk("rd_data", exp_q.pop_front(), rd_data);
    rd_take = 1'b1;
    @(negedge core_clk);
    rd_take = 1'b0;
  endtask : take
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    for (int a = 0; a < 16; a++) wr(a[AW-1:0], rnd(), 8'h00);
    for (int k = 0; k < 24; k++) begin
      wr(AW'($random(seed)), rnd(), k < 4 ? lns[k] : 8'($random(seed)));
    end
    // Two reads pile up in the buffer while nobody takes them
    for (int a = 0; a < 16; a += 2) begin
      rd(a[AW-1:0]);
      rd(AW'(a + 1));
      repeat (10) @(negedge core_clk);
      chk("rd_ready", 72'h0, {71'h0, rd_ready});
      take();
      take();
    end
    for (int k = 0; k < 12; k++) begin
      wr_addr = AW'($random(seed));
      rd(wr_addr);
      wr(wr_addr ^ 4'h1, rnd(), 8'($random(seed)));
      take();
    end
    repeat (6) @(negedge core_clk);
    chk("q_oe", 72'h0, {71'h0, link.q_oe});
    // Leave one burst in the buffer so the reset has something to clear
    rd(4'h5);
    repeat (10) @(negedge core_clk);
    chk("rd_valid", 72'h1, {71'h0, rd_valid});
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    exp_q.delete();
    chk("rd_valid", 72'h0, {71'h0, rd_valid});
    wr(4'h3, rnd(), 8'h00);
    rd(4'h3);
    take();
    conclude();
  end
endmodule : quad_rate_sram_port_interface_test
